// file: branch_pkg.sv
package branch_pkg;
   // opcodes of the two-byte relative branches
   localparam logic [7:0] OP_BRANCH_ALWAYS = 8'h20;
   localparam logic [7:0] OP_BRANCH_NEVER = 8'h21;
   localparam logic [7:0] OP_BRANCH_HIGHER = 8'h22;
   localparam logic [7:0] OP_BRANCH_LOWER_OR_SAME = 8'h23;
   localparam logic [7:0] OP_BRANCH_HIGHER_SAME_CARRY_CLEAR = 8'h24;
   localparam logic [7:0] OP_BRANCH_LOWER_CARRY_SET = 8'h25;
   localparam logic [7:0] OP_BRANCH_NOT_EQUAL = 8'h26;
   localparam logic [7:0] OP_BRANCH_EQUAL = 8'h27;
   localparam logic [7:0] OP_BRANCH_OVERFLOW_CLEAR = 8'h28;
   localparam logic [7:0] OP_BRANCH_OVERFLOW_SET = 8'h29;
   localparam logic [7:0] OP_BRANCH_PLUS = 8'h2a;
   localparam logic [7:0] OP_BRANCH_MINUS = 8'h2b;
   localparam logic [7:0] OP_BRANCH_SIGNED_GREATER_EQUAL = 8'h2c;
   localparam logic [7:0] OP_BRANCH_SIGNED_LESS = 8'h2d;
   localparam logic [7:0] OP_BRANCH_SIGNED_GREATER = 8'h2e;
   localparam logic [7:0] OP_BRANCH_SIGNED_LESS_EQUAL = 8'h2f;

   // bit positions inside the condition code register
   localparam int FLAG_STOP = 7;
   localparam int FLAG_XMASK = 6;
   localparam int FLAG_HALF = 5;
   localparam int FLAG_IMASK = 4;
   localparam int FLAG_NEG = 3;
   localparam int FLAG_ZERO = 2;
   localparam int FLAG_OVF = 1;
   localparam int FLAG_CARRY = 0;

   // bus figures
   localparam logic [15:0] DUMMY_ADDR = 16'hffff;
   localparam logic [15:0] INSTR_LEN = 16'h0002;
   localparam logic [15:0] OFFSET_STEP = 16'h0001;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [7:0] CCR_RESET = 8'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam int BUS_CYCLES = 3;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_FETCH_OP = 4'b0010,
      ST_FETCH_OFS = 4'b0100,
      ST_DUMMY = 4'b1000
   } branch_state_t;
endpackage

// file: branch_cond.sv
`timescale 1ns/1ps
`default_nettype none
// pure decode: which opcode is a branch, and whether the flags take it
module branch_cond (
   input wire logic [7:0] opcode,
   input wire logic [7:0] flags,
   output logic is_branch,
   output logic take
);
   logic n, z, v, c, nxv;

   // flag extraction; only the four condition flags are looked at
   always_comb begin
      n = flags[branch_pkg::FLAG_NEG];
      z = flags[branch_pkg::FLAG_ZERO];
      v = flags[branch_pkg::FLAG_OVF];
      c = flags[branch_pkg::FLAG_CARRY];
      nxv = n ^ v;
   end

   // condition table; unknown opcodes are never taken
   always_comb begin
      is_branch = 1'b1;
      take = 1'b0;
      case (opcode)
         branch_pkg::OP_BRANCH_ALWAYS: take = 1'b1;
         branch_pkg::OP_BRANCH_NEVER: take = 1'b0;
         branch_pkg::OP_BRANCH_HIGHER: take = ~(c | z);
         branch_pkg::OP_BRANCH_LOWER_OR_SAME: take = c | z;
         branch_pkg::OP_BRANCH_HIGHER_SAME_CARRY_CLEAR: take = ~c;
         branch_pkg::OP_BRANCH_LOWER_CARRY_SET: take = c;
         branch_pkg::OP_BRANCH_NOT_EQUAL: take = ~z;
         branch_pkg::OP_BRANCH_EQUAL: take = z;
         branch_pkg::OP_BRANCH_OVERFLOW_CLEAR: take = ~v;
         branch_pkg::OP_BRANCH_OVERFLOW_SET: take = v;
         branch_pkg::OP_BRANCH_PLUS: take = ~n;
         branch_pkg::OP_BRANCH_MINUS: take = n;
         branch_pkg::OP_BRANCH_SIGNED_GREATER_EQUAL: take = ~nxv;
         branch_pkg::OP_BRANCH_SIGNED_LESS: take = nxv;
         branch_pkg::OP_BRANCH_SIGNED_GREATER: take = ~(z | nxv);
         branch_pkg::OP_BRANCH_SIGNED_LESS_EQUAL: take = z | nxv;
         default: begin
            is_branch = 1'b0;
            take = 1'b0;
         end
      endcase
   end
endmodule
`default_nettype wire

// file: relative_branch_condition_unit.sv
// Behaviour
// - lower-or-same taken when carry or zero set
// - signed-less taken when negative xor overflow
// - minus branch tests only the negative flag
// - taken: pc becomes opcode address+2+signed offset
// - three reads: opcode, offset, dummy at ffff
// - all eight condition bits leave unchanged
// - signed greater, greater-equal, less-equal conditions
// - higher, carry-clear, carry-set conditions
// - equal, not-equal, plus, overflow conditions
// - always branch taken, never branch never
// - carry flag is never altered here
`timescale 1ns/1ps
`default_nettype none
module relative_branch_condition_unit (
   input wire logic clk,
   input wire logic nrst,
   input wire logic start,
   input wire logic [15:0] start_pc,
   input wire logic [7:0] ccr_in,
   output logic start_ready,
   output logic [15:0] mem_addr,
   output logic mem_rd,
   output logic mem_rw,
   input wire logic [7:0] mem_rdata,
   output logic done,
   output logic taken,
   output logic bad_opcode,
   output logic [15:0] next_pc,
   output logic [7:0] ccr_out
);
   branch_pkg::branch_state_t state_ff, nxt_state;
   logic [15:0] pc_ff, nxt_pc;
   logic [7:0] flags_ff, nxt_flags;
   logic [7:0] opcode_ff, nxt_opcode;
   logic [7:0] offset_ff, nxt_offset;
   logic [15:0] addr_ff, nxt_addr;
   logic rd_ff, nxt_rd;
   logic done_ff, nxt_done;
   logic taken_ff, nxt_taken;
   logic bad_ff, nxt_bad;
   logic [15:0] next_pc_ff, nxt_next_pc;
   logic cond_is_branch, cond_take;
   logic [15:0] fall_pc, target_pc;

   branch_cond u_cond (
      .opcode(opcode_ff),
      .flags(flags_ff),
      .is_branch(cond_is_branch),
      .take(cond_take)
   );

   // destination arithmetic; the offset byte is two's complement
   assign fall_pc = pc_ff + branch_pkg::INSTR_LEN;
   assign target_pc = fall_pc + {{8{offset_ff[7]}}, offset_ff};

   // handshake and registered outputs
   assign start_ready = (state_ff == branch_pkg::ST_IDLE);
   assign mem_addr = addr_ff;
   assign mem_rd = rd_ff;
   assign mem_rw = 1'b1; // every cycle of a branch is a read
   assign done = done_ff;
   assign taken = taken_ff;
   assign bad_opcode = bad_ff;
   assign next_pc = next_pc_ff;
   // flags are handed back exactly as captured; nothing here writes them
   assign ccr_out = flags_ff;

   // sequencer: opcode read, offset read, dummy read, then report
   always_comb begin
      nxt_state = state_ff;
      nxt_pc = pc_ff;
      nxt_flags = flags_ff;
      nxt_opcode = opcode_ff;
      nxt_offset = offset_ff;
      nxt_addr = addr_ff;
      nxt_rd = 1'b0;
      nxt_done = 1'b0;
      nxt_taken = taken_ff;
      nxt_bad = bad_ff;
      nxt_next_pc = next_pc_ff;
      case (state_ff)
         branch_pkg::ST_IDLE: begin
            if (start) begin
               nxt_state = branch_pkg::ST_FETCH_OP;
               nxt_pc = start_pc;
               nxt_flags = ccr_in;
               nxt_addr = start_pc;
               nxt_rd = 1'b1;
            end
         end
         branch_pkg::ST_FETCH_OP: begin
            nxt_opcode = mem_rdata;
            nxt_state = branch_pkg::ST_FETCH_OFS;
            nxt_addr = pc_ff + branch_pkg::OFFSET_STEP;
            nxt_rd = 1'b1;
         end
         branch_pkg::ST_FETCH_OFS: begin
            nxt_offset = mem_rdata;
            nxt_state = branch_pkg::ST_DUMMY;
            nxt_addr = branch_pkg::DUMMY_ADDR;
            nxt_rd = 1'b1;
         end
         branch_pkg::ST_DUMMY: begin
            // the decision is ready during the dummy read, so it is
            // registered at its end and the next fetch address is correct
            nxt_state = branch_pkg::ST_IDLE;
            nxt_done = 1'b1;
            nxt_taken = cond_take;
            nxt_bad = ~cond_is_branch;
            nxt_next_pc = cond_take ? target_pc : fall_pc;
         end
         default: begin
            nxt_state = branch_pkg::ST_IDLE;
         end
      endcase
   end

   // state registers, synchronous active-low reset
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_ff <= branch_pkg::ST_IDLE;
         pc_ff <= branch_pkg::PC_RESET;
         flags_ff <= branch_pkg::CCR_RESET;
         opcode_ff <= branch_pkg::BYTE_RESET;
         offset_ff <= branch_pkg::BYTE_RESET;
         addr_ff <= branch_pkg::PC_RESET;
         rd_ff <= 1'b0;
         done_ff <= 1'b0;
         taken_ff <= 1'b0;
         bad_ff <= 1'b0;
         next_pc_ff <= branch_pkg::PC_RESET;
      end else begin
         state_ff <= nxt_state;
         pc_ff <= nxt_pc;
         flags_ff <= nxt_flags;
         opcode_ff <= nxt_opcode;
         offset_ff <= nxt_offset;
         addr_ff <= nxt_addr;
         rd_ff <= nxt_rd;
         done_ff <= nxt_done;
         taken_ff <= nxt_taken;
         bad_ff <= nxt_bad;
         next_pc_ff <= nxt_next_pc;
      end
   end

   // checks: decisions are judged against the flags seen at start
   chk_lower_same_cond: assert property (@(posedge clk) disable iff (!nrst)
      done && opcode_ff == branch_pkg::OP_BRANCH_LOWER_OR_SAME
      |-> taken == ($past(ccr_in[branch_pkg::FLAG_CARRY], 4) | $past(ccr_in[branch_pkg::FLAG_ZERO], 4)))
      else $error("lower-or-same decision wrong");

   chk_signed_less_cond: assert property (@(posedge clk) disable iff (!nrst)
      done && opcode_ff == branch_pkg::OP_BRANCH_SIGNED_LESS
      |-> taken == (flags_ff[branch_pkg::FLAG_NEG] ^ flags_ff[branch_pkg::FLAG_OVF]))
      else $error("signed-less decision wrong");

   chk_minus_cond: assert property (@(posedge clk) disable iff (!nrst)
      done && opcode_ff == branch_pkg::OP_BRANCH_MINUS |-> taken == flags_ff[branch_pkg::FLAG_NEG])
      else $error("minus decision wrong");

   chk_taken_target: assert property (@(posedge clk) disable iff (!nrst)
      done && taken |-> next_pc == pc_ff + 16'h0002 + {{8{offset_ff[7]}}, offset_ff})
      else $error("taken target wrong");

   chk_bus_sequence: assert property (@(posedge clk) disable iff (!nrst)
      start && start_ready
      |=> mem_rd && mem_rw && mem_addr == $past(start_pc)
      ##1 mem_rd && mem_addr == $past(start_pc, 2) + 16'h0001
      ##1 mem_rd && mem_addr == 16'hffff
      ##1 !mem_rd && done)
      else $error("bus cycle sequence wrong");

   chk_flags_kept: assert property (@(posedge clk) disable iff (!nrst)
      done |-> ccr_out == $past(ccr_in, 4))
      else $error("condition bits changed");

   chk_signed_group: assert property (@(posedge clk) disable iff (!nrst)
      done && opcode_ff == branch_pkg::OP_BRANCH_SIGNED_GREATER
      |-> taken == !(flags_ff[branch_pkg::FLAG_ZERO]
                     || (flags_ff[branch_pkg::FLAG_NEG] != flags_ff[branch_pkg::FLAG_OVF])))
      else $error("signed-greater decision wrong");

   chk_unsigned_group: assert property (@(posedge clk) disable iff (!nrst)
      done && opcode_ff == branch_pkg::OP_BRANCH_HIGHER
      |-> taken == !(flags_ff[branch_pkg::FLAG_CARRY] || flags_ff[branch_pkg::FLAG_ZERO]))
      else $error("higher decision wrong");

   chk_equal_cond: assert property (@(posedge clk) disable iff (!nrst)
      done && (opcode_ff == branch_pkg::OP_BRANCH_EQUAL || opcode_ff == branch_pkg::OP_BRANCH_NOT_EQUAL)
      |-> taken == (flags_ff[branch_pkg::FLAG_ZERO] == opcode_ff[0]))
      else $error("equal decision wrong");

   chk_always_never: assert property (@(posedge clk) disable iff (!nrst)
      done && opcode_ff[7:1] == 7'h10 |-> taken == !opcode_ff[0])
      else $error("always or never decision wrong");

   chk_carry_passed: assert property (@(posedge clk) disable iff (!nrst)
      done |-> ccr_out[branch_pkg::FLAG_CARRY] == $past(ccr_in[branch_pkg::FLAG_CARRY], 4))
      else $error("carry altered");

   chk_fall_through: assert property (@(posedge clk) disable iff (!nrst)
      done && !taken |-> next_pc == $past(start_pc, 4) + 16'h0002)
      else $error("fall-through address wrong");

   // a start accepted alongside the previous done is legal, so done is only
   // judged from the cycle after acceptance on
   chk_result_timing: assert property (@(posedge clk) disable iff (!nrst)
      start && start_ready |=> !done [*3] ##1 done && start_ready ##1 !done)
      else $error("result not ready after third cycle");

   // results stand untouched between two reports
   chk_result_hold: assert property (@(posedge clk) disable iff (!nrst)
      !done |-> $stable(taken) && $stable(next_pc) && $stable(bad_opcode))
      else $error("result changed between reports");

   // opcodes outside the branch group are flagged and fall through
   chk_bad_opcode: assert property (@(posedge clk) disable iff (!nrst)
      done |-> bad_opcode == (opcode_ff < branch_pkg::OP_BRANCH_ALWAYS
                              || opcode_ff > branch_pkg::OP_BRANCH_SIGNED_LESS_EQUAL))
      else $error("opcode class wrong");

   // no bus read while idle
   chk_idle_no_read: assert property (@(posedge clk) disable iff (!nrst)
      start_ready |-> !mem_rd)
      else $error("read while idle");
endmodule
`default_nettype wire

// file: program_memory.sv
`timescale 1ns/1ps
`default_nettype none
// program memory on the processor bus: one read per clock, data in the same cycle
module program_memory (
   input wire logic clk,
   input wire logic [15:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_rw,
   output logic [7:0] mem_rdata
);
   logic [7:0] mem [logic [15:0]];
   logic [7:0] junk_ff = 8'h3c;

   // idle bus shows a pattern that changes every cycle, so a stale byte never looks valid
   always @(posedge clk) begin
      junk_ff <= junk_ff + 8'h5b;
   end

   // unwritten places, such as the dummy address, also return junk
   always @* begin
      if (mem_rd && mem_rw && mem.exists(mem_addr)) begin
         mem_rdata = mem[mem_addr];
      end else begin
         mem_rdata = junk_ff;
      end
   end
endmodule
`default_nettype wire

// file: relative_branch_condition_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
module relative_branch_condition_unit_bench;
   logic clk, nrst, start, start_ready, mem_rd, mem_rw, done, taken, bad_opcode;
   logic [15:0] start_pc, mem_addr, next_pc, seed;
   logic [7:0] ccr_in, mem_rdata, ccr_out;
   int n_mismatch = 0;
   int tests_run = 0;
   int cycles = 0;

   relative_branch_condition_unit relative_branch_condition_unit_inst (.clk(clk), .nrst(nrst), .start(start),
      .start_pc(start_pc), .ccr_in(ccr_in), .start_ready(start_ready), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_rw(mem_rw), .mem_rdata(mem_rdata), .done(done), .taken(taken), .bad_opcode(bad_opcode),
      .next_pc(next_pc), .ccr_out(ccr_out));
   program_memory program_memory_inst (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rw(mem_rw),
      .mem_rdata(mem_rdata));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // expected branch decision worked out from the flags alone
   function automatic logic exp_take(input logic [7:0] op, input logic [7:0] f);
      logic n, z, v, c;
      n = f[branch_pkg::FLAG_NEG];
      z = f[branch_pkg::FLAG_ZERO];
      v = f[branch_pkg::FLAG_OVF];
      c = f[branch_pkg::FLAG_CARRY];
      case (op)
         8'h20: return 1'b1;
         8'h22: return !(c | z);
         8'h23: return c | z;
         8'h24: return !c;
         8'h25: return c;
         8'h26: return !z;
         8'h27: return z;
         8'h28: return !v;
         8'h29: return v;
         8'h2a: return !n;
         8'h2b: return n;
         8'h2c: return !(n ^ v);
         8'h2d: return n ^ v;
         8'h2e: return !(z | (n ^ v));
         8'h2f: return z | (n ^ v);
         default: return 1'b0;
      endcase
   endfunction

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // one branch from start to done; entered and left at a falling edge
   task automatic run_op(input logic [7:0] op, input logic [7:0] ofs, input logic [15:0] pc, input logic [7:0] condition_code_register);
      logic tk;
      logic [15:0] npc;
      tk = exp_take(op, condition_code_register);
      npc = pc + 16'h0002 + (tk ? {{8{ofs[7]}}, ofs} : 16'h0000);
      program_memory_inst.mem[pc] = op;
      program_memory_inst.mem[pc + 16'h0001] = ofs;
      start = 1'b1;
      start_pc = pc;
      ccr_in = condition_code_register;
      @(negedge clk);
      chk("fetch op", pc, mem_addr);
      chk("fetch op rd", 16'h0001, {15'h0, mem_rd});
      chk("busy", 16'h0000, {15'h0, start_ready});
      start = 1'b0;
      start_pc = ~pc;
      ccr_in = ~condition_code_register; // flags changed after start must not matter
      @(negedge clk);
      chk("fetch ofs", pc + 16'h0001, mem_addr);
      chk("fetch ofs rd", 16'h0001, {15'h0, mem_rd});
      start = 1'b1; // refused while busy
      @(negedge clk);
      chk("dummy", branch_pkg::DUMMY_ADDR, mem_addr);
      chk("dummy rd", 16'h0001, {15'h0, mem_rd});
      chk("rw", 16'h0001, {15'h0, mem_rw});
      start = 1'b0;
      @(negedge clk);
      chk("done", 16'h0005, {13'h0, done, mem_rd, start_ready});
      chk("taken", {15'h0, tk}, {15'h0, taken});
      chk("bad_opcode", {15'h0, op[7:4] != 4'h2}, {15'h0, bad_opcode});
      chk("next_pc", npc, next_pc);
      chk("ccr_out", {8'h00, condition_code_register}, {8'h00, ccr_out});
      @(negedge clk);
      chk("done end", 16'h0000, {15'h0, done});
   endtask

   // hang guard: the whole run needs some 1200 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         conclude();
      end
   end

   initial begin
      nrst = 1'b0;
      start = 1'b0;
      start_pc = 16'h0000;
      ccr_in = 8'h00;
      seed = 16'hacd7;
      repeat (16) @(posedge clk);
      @(negedge clk);
      nrst = 1'b1;
      // every opcode with flags all clear and all set, extreme offsets, pc wrap
      for (int i = 0; i < 16; i++) begin
         run_op(8'h20 + 8'(i), 8'h80, 16'h1000, 8'h00);
         run_op(8'h20 + 8'(i), 8'h7f, 16'hfffd, 8'hff);
      end
      run_op(8'h1f, 8'h10, 16'h2000, 8'hff);
      run_op(8'h30, 8'h10, 16'h2000, 8'hff);
      $display("corner tests done");
      // random opcodes, offsets, flags and addresses
      for (int i = 0; i < 200; i++) begin
         seed = lfsr_next(seed);
         start_pc = seed;
         seed = lfsr_next(seed);
         run_op({4'h2, seed[3:0]}, seed[15:8], start_pc, seed[11:4]);
      end
      $display("random tests done");
      conclude();
   end
endmodule
`default_nettype wire
